// ===== logic/pd_gain_pkg.sv
// constants for the phase detector gain select registers of both loops
// assumes a byte-wide microprocessor register port and a 25 MHz system clock
package pd_gain_pkg;
    localparam logic [6:0] AUX_GAIN_ADDR  = 7'h6C;
    localparam logic [6:0] MAIN_GAIN_ADDR = 7'h6D;
    localparam logic [7:0] GAIN_RESET     = 8'hC2;
    localparam logic [7:0] GAIN_WR_MASK   = 8'hF7;  // bit 3 unused
    localparam int         ENABLE_BIT     = 7;
    localparam int         ANALOG_LSB     = 4;
    localparam int         DIGITAL_LSB    = 0;
    // locking mode of a loop as reported by its controller
    typedef enum logic [1:0] {
        MODE_DIGITAL     = 2'b00,
        MODE_ANALOG_HIGH = 2'b01,
        MODE_ANALOG_LOW  = 2'b10
    } lock_mode_t;
endpackage : pd_gain_pkg

// ===== logic/pd_gain_select.sv
// register bank and gain selection for the second phase detector of two loops
// assumes a synchronous byte register port; the low-frequency analog gain of each
// loop lives in a neighbouring register and arrives here as an input

// How it works
// - auxiliary loop enable bit at 0 turns off the mode-based gain choice, at 1 picks by locking mode.
// - auxiliary analog gain field sets the gain only in analog mode above 8 kHz with auto select on.
// - main analog gain field sets the gain in high-frequency analog mode and is ignored with auto select off.
// - auxiliary digital gain field sets the gain in digital mode and always when auto select is off.
// - both gain registers reset to 1100 0010.
// - main digital gain field sets the gain in digital mode and always when auto select is off.
module pd_gain_select (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // register port
    input  wire logic [6:0]               reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic [7:0]               reg_wdata,
    output logic      [7:0]               reg_rdata,
    // loop state
    input  wire pd_gain_pkg::lock_mode_t  aux_mode,
    input  wire pd_gain_pkg::lock_mode_t  main_mode,
    input  wire logic [2:0]               aux_analog_low_gain,
    input  wire logic [2:0]               main_analog_low_gain,
    // selected phase detector gains
    output logic      [2:0]               aux_pd_gain,
    output logic      [2:0]               main_pd_gain
);
    // one byte of storage per loop; bit 3 is never stored as a one
    logic [7:0] aux_gain_q;
    logic [7:0] main_gain_q;

    // register fields by name, used by the checks below; the gain picks tap the registers directly
    logic       aux_auto_gain_enable;
    logic [2:0] aux_analog_gain;
    logic [2:0] aux_digital_gain;
    logic       main_auto_gain_enable;
    logic [2:0] main_analog_gain;
    logic [2:0] main_digital_gain;

    // field taps of the auxiliary loop register
    assign aux_auto_gain_enable  = aux_gain_q[pd_gain_pkg::ENABLE_BIT];
    assign aux_analog_gain       = aux_gain_q[pd_gain_pkg::ANALOG_LSB +: 3];
    assign aux_digital_gain      = aux_gain_q[pd_gain_pkg::DIGITAL_LSB +: 3];

    // field taps of the main loop register
    assign main_auto_gain_enable = main_gain_q[pd_gain_pkg::ENABLE_BIT];
    assign main_analog_gain      = main_gain_q[pd_gain_pkg::ANALOG_LSB +: 3];
    assign main_digital_gain     = main_gain_q[pd_gain_pkg::DIGITAL_LSB +: 3];

    // keeps the unused bit 3 at zero whatever software writes
    function automatic logic [7:0] masked_write(input logic [7:0] d);
        return d & pd_gain_pkg::GAIN_WR_MASK;
    endfunction : masked_write

    // picks a gain field from the register and locking mode
    function automatic logic [2:0] pick_gain(input logic [7:0] r, input pd_gain_pkg::lock_mode_t m,
                                             input logic [2:0] low);
        logic [2:0] g;
        g = r[pd_gain_pkg::DIGITAL_LSB +: 3];
        if (r[pd_gain_pkg::ENABLE_BIT]) begin
            case (m)
                pd_gain_pkg::MODE_ANALOG_HIGH: g = r[pd_gain_pkg::ANALOG_LSB +: 3];
                pd_gain_pkg::MODE_ANALOG_LOW:  g = low;
                default:                       g = r[pd_gain_pkg::DIGITAL_LSB +: 3];
            endcase
        end
        return g;
    endfunction : pick_gain

    // auxiliary register; masking write keeps bit 3 at zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aux_gain_q <= pd_gain_pkg::GAIN_RESET;
        end else if (reg_wr && reg_addr == pd_gain_pkg::AUX_GAIN_ADDR) begin
            aux_gain_q <= masked_write(reg_wdata);
        end
    end

    // main register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            main_gain_q <= pd_gain_pkg::GAIN_RESET;
        end else if (reg_wr && reg_addr == pd_gain_pkg::MAIN_GAIN_ADDR) begin
            main_gain_q <= masked_write(reg_wdata);
        end
    end

    // auxiliary gain registered so the detector sees a clean value;
    // it lags a register write or a mode change by one cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aux_pd_gain <= pd_gain_pkg::GAIN_RESET[2:0];
        end else begin
            aux_pd_gain <= pick_gain(aux_gain_q, aux_mode, aux_analog_low_gain);
        end
    end

    // main gain, same one-cycle lag as the auxiliary one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            main_pd_gain <= pd_gain_pkg::GAIN_RESET[2:0];
        end else begin
            main_pd_gain <= pick_gain(main_gain_q, main_mode, main_analog_low_gain);
        end
    end

    // read data; unmapped addresses return zero
    always_comb begin
        case (reg_addr)
            pd_gain_pkg::AUX_GAIN_ADDR:  reg_rdata = aux_gain_q;
            pd_gain_pkg::MAIN_GAIN_ADDR: reg_rdata = main_gain_q;
            default:                     reg_rdata = 8'h00;
        endcase
    end

    AST_RESET_VALUE: assert property (@(posedge core_clk) rst |=> aux_gain_q == 8'hC2 && main_gain_q == 8'hC2)
        else $error("gain register not at reset value");
    AST_BIT3_ZERO: assert property (@(posedge core_clk) disable iff (rst) !aux_gain_q[3] && !main_gain_q[3])
        else $error("unused bit 3 set");
    AST_AUX_DISABLED: assert property (@(posedge core_clk) disable iff (rst)
        !aux_gain_q[7] |=> aux_pd_gain == $past(aux_gain_q[2:0])) else $error("aux gain not digital when disabled");
    AST_MAIN_DISABLED: assert property (@(posedge core_clk) disable iff (rst)
        !main_gain_q[7] |=> main_pd_gain == $past(main_gain_q[2:0])) else $error("main gain not digital when disabled");
    AST_AUX_ANALOG: assert property (@(posedge core_clk) disable iff (rst)
        aux_gain_q[7] && aux_mode == pd_gain_pkg::MODE_ANALOG_HIGH |=> aux_pd_gain == $past(aux_gain_q[6:4]))
        else $error("aux analog gain not used");
    AST_MAIN_ANALOG: assert property (@(posedge core_clk) disable iff (rst)
        main_gain_q[7] && main_mode == pd_gain_pkg::MODE_ANALOG_HIGH |=> main_pd_gain == $past(main_gain_q[6:4]))
        else $error("main analog gain not used");
    AST_AUX_MODE: assert property (@(posedge core_clk) disable iff (rst)
        aux_gain_q[7] && aux_mode == pd_gain_pkg::MODE_ANALOG_LOW |=> aux_pd_gain == $past(aux_analog_low_gain))
        else $error("aux low gain not used");
    AST_MAIN_MODE: assert property (@(posedge core_clk) disable iff (rst)
        main_gain_q[7] && main_mode == pd_gain_pkg::MODE_DIGITAL |=> main_pd_gain == $past(main_gain_q[2:0]))
        else $error("main digital gain not used");

    // gain outputs leave reset at the digital field of the reset value
    AST_GAIN_RESET: assert property (@(posedge core_clk)
        rst |=> aux_pd_gain == 3'h2 && main_pd_gain == 3'h2)
        else $error("gain output not at reset value");

    // auxiliary loop in digital mode with auto select on uses the digital field
    AST_AUX_DIGITAL: assert property (@(posedge core_clk) disable iff (rst)
        aux_auto_gain_enable && aux_mode == pd_gain_pkg::MODE_DIGITAL |=> aux_pd_gain == $past(aux_digital_gain))
        else $error("aux digital gain not used");

    // main loop in low analog mode with auto select on uses the low gain input
    AST_MAIN_LOW: assert property (@(posedge core_clk) disable iff (rst)
        main_auto_gain_enable && main_mode == pd_gain_pkg::MODE_ANALOG_LOW
        |=> main_pd_gain == $past(main_analog_low_gain))
        else $error("main low gain not used");

    // the spare mode code falls back to the digital field, so a glitch cannot pick a stray gain
    AST_AUX_SPARE_MODE: assert property (@(posedge core_clk) disable iff (rst)
        aux_auto_gain_enable && aux_mode == 2'b11 |=> aux_pd_gain == $past(aux_digital_gain))
        else $error("aux spare mode not digital");

    // same fallback on the main loop
    AST_MAIN_SPARE_MODE: assert property (@(posedge core_clk) disable iff (rst)
        main_auto_gain_enable && main_mode == 2'b11 |=> main_pd_gain == $past(main_digital_gain))
        else $error("main spare mode not digital");

    // analog field is ignored while auto select is off
    AST_AUX_ANALOG_OFF: assert property (@(posedge core_clk) disable iff (rst)
        !aux_auto_gain_enable && aux_mode == pd_gain_pkg::MODE_ANALOG_HIGH
        |=> aux_pd_gain == $past(aux_digital_gain))
        else $error("aux analog gain used while disabled");

    // same on the main loop
    AST_MAIN_ANALOG_OFF: assert property (@(posedge core_clk) disable iff (rst)
        !main_auto_gain_enable && main_mode == pd_gain_pkg::MODE_ANALOG_HIGH
        |=> main_pd_gain == $past(main_digital_gain))
        else $error("main analog gain used while disabled");

    // low analog mode does not steer the auxiliary gain while auto select is off
    AST_AUX_LOW_OFF: assert property (@(posedge core_clk) disable iff (rst)
        !aux_auto_gain_enable && aux_mode == pd_gain_pkg::MODE_ANALOG_LOW
        |=> aux_pd_gain == $past(aux_digital_gain))
        else $error("aux low gain used while disabled");

    // same on the main loop
    AST_MAIN_LOW_OFF: assert property (@(posedge core_clk) disable iff (rst)
        !main_auto_gain_enable && main_mode == pd_gain_pkg::MODE_ANALOG_LOW
        |=> main_pd_gain == $past(main_digital_gain))
        else $error("main low gain used while disabled");

    // a write to the auxiliary register lands with bit 3 cleared
    AST_AUX_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == pd_gain_pkg::AUX_GAIN_ADDR |=> aux_gain_q == ($past(reg_wdata) & 8'hF7))
        else $error("aux write not stored");

    // a write to the main register lands with bit 3 cleared
    AST_MAIN_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == pd_gain_pkg::MAIN_GAIN_ADDR |=> main_gain_q == ($past(reg_wdata) & 8'hF7))
        else $error("main write not stored");

    // the auxiliary settings change only on a write to their own address
    AST_AUX_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !(reg_wr && reg_addr == pd_gain_pkg::AUX_GAIN_ADDR) |=> aux_gain_q == $past(aux_gain_q))
        else $error("aux register changed without a write");

    // the main settings change only on a write to their own address
    AST_MAIN_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !(reg_wr && reg_addr == pd_gain_pkg::MAIN_GAIN_ADDR) |=> main_gain_q == $past(main_gain_q))
        else $error("main register changed without a write");

    // reads return the addressed register and zero elsewhere
    AST_READ_MAP: assert property (@(posedge core_clk) disable iff (rst)
        (reg_addr == pd_gain_pkg::AUX_GAIN_ADDR) ? reg_rdata == aux_gain_q :
        (reg_addr == pd_gain_pkg::MAIN_GAIN_ADDR) ? reg_rdata == main_gain_q : reg_rdata == 8'h00)
        else $error("read data does not match address");

    // bit 3 always reads zero
    AST_READ_BIT3: assert property (@(posedge core_clk) disable iff (rst)
        !reg_rdata[3])
        else $error("read bit 3 set");

    // gain moves only when its register, mode or low input moved; the reset
    // cycle is excluded since the reset value need not match the pick
    AST_AUX_STEADY: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && $stable(aux_gain_q) && $stable(aux_mode) && $stable(aux_analog_low_gain)
        |=> $stable(aux_pd_gain))
        else $error("aux gain moved with steady inputs");

    // same for the main loop
    AST_MAIN_STEADY: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && $stable(main_gain_q) && $stable(main_mode) && $stable(main_analog_low_gain)
        |=> $stable(main_pd_gain))
        else $error("main gain moved with steady inputs");
endmodule : pd_gain_select

// ===== verif/pd_gain_select_bench.sv
// bench for the gain select registers: reset values, bit 3, unmapped reads, gain per mode
// assumes the design drives reg_rdata combinationally and registers the gains
module pd_gain_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   core_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0;
    logic [6:0]             reg_addr = 7'h00;
    logic [7:0]             reg_wdata = 8'h00;
    logic [7:0]             reg_rdata;
    logic [2:0]             aux_pd_gain, main_pd_gain, aux_lo = 3'h1, main_lo = 3'h7;
    pd_gain_pkg::lock_mode_t aux_mode = pd_gain_pkg::MODE_DIGITAL, main_mode = pd_gain_pkg::MODE_DIGITAL;
    int                     num_errors = 0, check_count = 0, cycles = 0;
    pd_gain_select pd_gain_select_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .aux_mode(aux_mode), .main_mode(main_mode),
        .aux_analog_low_gain(aux_lo), .main_analog_low_gain(main_lo),
        .aux_pd_gain(aux_pd_gain), .main_pd_gain(main_pd_gain));
    // 25 MHz clock and a hang guard well past the roughly 50 cycles needed
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // a write is taken at the edge where reg_wr is seen high
    task automatic wr(logic [6:0] a, logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(logic [6:0] a, logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        #1 chk("rdata", reg_rdata, exp);
    endtask : rd
    // expected gain: analog high field, low input, else digital field
    function automatic logic [2:0] want(int e, int m, logic [2:0] an, logic [2:0] lo, logic [2:0] dg);
        return (e == 1 && m == 1) ? an : (e == 1 && m == 2) ? lo : dg;
    endfunction : want
    task automatic t_reset();
        rd(7'h6C, 8'hC2); rd(7'h6D, 8'hC2);
        chk("aux gain", {5'h00, aux_pd_gain}, 8'h02);
        chk("main gain", {5'h00, main_pd_gain}, 8'h02);
    endtask : t_reset
    task automatic t_bit3();
        wr(7'h6C, 8'hFF); wr(7'h6D, 8'h08); wr(7'h6E, 8'hFF);
        rd(7'h6C, 8'hF7); rd(7'h6D, 8'h00); rd(7'h6E, 8'h00);
    endtask : t_bit3
    task automatic t_select();
        for (int e = 0; e < 2; e++) begin
            wr(7'h6C, e ? 8'hB5 : 8'h35); wr(7'h6D, e ? 8'hE3 : 8'h63);
            for (int m = 0; m < 4; m++) begin
                @(posedge core_clk);
                aux_mode <= pd_gain_pkg::lock_mode_t'(m); main_mode <= pd_gain_pkg::lock_mode_t'(3 - m);
                repeat (2) @(posedge core_clk);
                #1 chk("aux gain", {5'h00, aux_pd_gain}, {5'h00, want(e, m, 3'h3, aux_lo, 3'h5)});
                chk("main gain", {5'h00, main_pd_gain}, {5'h00, want(e, 3 - m, 3'h6, main_lo, 3'h3)});
            end
        end
    endtask : t_select
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'h0;
        t_reset(); t_bit3(); t_select();
        give_verdict();
    end
endmodule : pd_gain_select_bench
